// file: common/ptmr_regs.svh
// Register offsets, field positions and reset values of the periodic timer
// ****************************************************************************
// Overview of operation
// R1: Capture input from A4 or B5 by route
// R2: External clock from A3 or B4 by route
// R3: Compare match raises event, clears counter, drives pin
// R4: Three-bit field selects the counter clock source
// R5: Separate events for comparator A and period
// R6: External clock counts on selected rising/falling edge
// R7: External clock pin triggers single pulse output
// R8: Capture on rising, falling or both edges
// R9: External clock pin may replace capture input
// R10: Output pins set, clear, toggle or carry PWM
// R11: Software adjusts PWM period and duty
// R12: Software enables pin sharing before use
// R13: High bytes direct, low bytes via one buffer
// R14: Comparator low write only loads the buffer
// R15: Comparator high write also moves buffer low
// R16: High read copies matching low into buffer
// R17: Low read returns buffer, not live byte
// R18: Software writes low first, reads high first
// R19: Ten-bit up-counter, comparators use all bits
// R20: Second output pin always inverts the first
// R21: One buffer; captures land in comparator A
// ****************************************************************************
`ifndef PTMR_REGS_SVH
`define PTMR_REGS_SVH

// ****************************************************************************
// Register offsets
// ****************************************************************************
`define PTMR_ADDR_CTRL0 4'h0
`define PTMR_ADDR_CTRL1 4'h1
`define PTMR_ADDR_CNT_LO 4'h2
`define PTMR_ADDR_CNT_HI 4'h3
`define PTMR_ADDR_CMPA_LO 4'h4
`define PTMR_ADDR_CMPA_HI 4'h5
`define PTMR_ADDR_PER_LO 4'h6
`define PTMR_ADDR_PER_HI 4'h7
`define PTMR_ADDR_ROUTE 4'h8

// ****************************************************************************
// Field positions
// ****************************************************************************
`define PTMR_C0_PAUSE 7
`define PTMR_C0_CKSEL 6:4
`define PTMR_C0_ON 3
`define PTMR_C1_MODE 7:6
`define PTMR_C1_FN 5:4
`define PTMR_C1_INIT 3
`define PTMR_C1_POL 2
`define PTMR_C1_CAPSRC 1
`define PTMR_C1_CCLR 0
`define PTMR_RT_CAP 3:2
`define PTMR_RT_CLK 1:0
`define PTMR_HI_BITS 1:0

// ****************************************************************************
// Encodings and reset values
// ****************************************************************************
`define PTMR_MODE_CMP 2'h0
`define PTMR_MODE_CAP 2'h1
`define PTMR_MODE_PWM 2'h2
`define PTMR_MODE_TMR 2'h3
`define PTMR_FN_0 2'h0
`define PTMR_FN_1 2'h1
`define PTMR_FN_2 2'h2
`define PTMR_FN_3 2'h3
`define PTMR_CK_SYS4 3'h0
`define PTMR_CK_SYS 3'h1
`define PTMR_CK_H16 3'h2
`define PTMR_CK_H64 3'h3
`define PTMR_CK_SUB0 3'h4
`define PTMR_CK_SUB1 3'h5
`define PTMR_CK_EXTR 3'h6
`define PTMR_CK_EXTF 3'h7
`define PTMR_DIV_SYS 4
`define PTMR_DIV_H16 16
`define PTMR_DIV_H64 64
`define PTMR_RST_BYTE 8'h00
`define PTMR_RST_CNT 10'h000

`endif

// file: common/ptmr_pkg.sv
// Types shared by the periodic timer modules
package ptmr_pkg;
  typedef struct packed {
    logic pause;
    logic [2:0] cksel;
    logic on;
    logic [1:0] mode;
    logic [1:0] fn;
    logic init;
    logic pol;
    logic capsrc;
    logic cclr;
    logic [3:0] route;
    logic [9:0] cnt;
    logic [9:0] cmp_a;
    logic [9:0] per;
    logic [7:0] lo_buf;
    logic [7:0] rdata;
    logic out;
    logic on_prev;
    logic sp_run;
    logic ext_prev;
    logic cap_prev;
    logic irq_a;
    logic irq_p;
  } ptmr_state_type;

  typedef struct packed {
    logic meta;
    logic level;
  } ptmr_sync_type;
endpackage

// file: hdl/ptmr_sync.sv
// Two-stage synchroniser for a pin or foreign clock level
module ptmr_sync
  import ptmr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic pin_in,
  output logic level_out
);
  ptmr_sync_type st_q;
  ptmr_sync_type st_d;

  always_comb begin
    st_d.meta = pin_in;
    st_d.level = st_q.meta;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.level;
endmodule

// file: hdl/ptmr_prescale.sv
// Tick divider: one output tick per DIV input ticks
module ptmr_prescale
  import ptmr_pkg::*;
#(
  parameter int DIV = 4
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic in_tick,
  output logic out_tick
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (in_tick) begin
      cnt_d = (cnt_q == LAST) ? '0 : cnt_q + CW'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Combinational tick keeps the divided clock phase aligned with the source
  assign out_tick = in_tick && (cnt_q == LAST);
endmodule

// file: hdl/ptmr_core.sv
// Periodic timer core: counter, comparators, capture, outputs and byte access
`include "ptmr_regs.svh"
module ptmr_core
  import ptmr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic port_a_bit_three,
  input wire logic port_a_bit_four,
  input wire logic port_b_bit_four,
  input wire logic port_b_bit_five,
  input wire logic high_clk,
  input wire logic sub_clk,
  output logic timer_output_pin,
  output logic timer_output_inverted_pin,
  output logic irq_compare_a,
  output logic irq_period
);
  ptmr_state_type st_q;
  ptmr_state_type st_d;

  logic pa3_s;
  logic pa4_s;
  logic pb4_s;
  logic pb5_s;
  logic hclk_s;
  logic sclk_s;
  logic hclk_prev_q;
  logic sclk_prev_q;
  logic hclk_tick;
  logic sclk_tick;
  logic sys4_tick;
  logic h16_tick;
  logic h64_tick;
  logic ext_lvl;
  logic cap_lvl;
  logic ext_rise;
  logic ext_fall;
  logic cap_rise;
  logic cap_fall;
  logic src_rise;
  logic src_fall;
  logic src_tick;
  logic run;
  logic cnt_tick;
  logic match_a;
  logic match_p;
  logic clear_hit;
  logic cap_hit;
  logic on_rise;

  // ****************************************************************************
  // Pin and clock synchronisers
  // ****************************************************************************
  ptmr_sync u_sync_pa3 (.ref_clk(ref_clk), .sys_rst(sys_rst), .pin_in(port_a_bit_three),
    .level_out(pa3_s));
  ptmr_sync u_sync_pa4 (.ref_clk(ref_clk), .sys_rst(sys_rst), .pin_in(port_a_bit_four),
    .level_out(pa4_s));
  ptmr_sync u_sync_pb4 (.ref_clk(ref_clk), .sys_rst(sys_rst), .pin_in(port_b_bit_four),
    .level_out(pb4_s));
  ptmr_sync u_sync_pb5 (.ref_clk(ref_clk), .sys_rst(sys_rst), .pin_in(port_b_bit_five),
    .level_out(pb5_s));
  ptmr_sync u_sync_hclk (.ref_clk(ref_clk), .sys_rst(sys_rst), .pin_in(high_clk),
    .level_out(hclk_s));
  ptmr_sync u_sync_sclk (.ref_clk(ref_clk), .sys_rst(sys_rst), .pin_in(sub_clk),
    .level_out(sclk_s));

  // Foreign clocks are sampled, so they must run below half of ref_clk
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hclk_prev_q <= 1'b0;
      sclk_prev_q <= 1'b0;
    end else begin
      hclk_prev_q <= hclk_s;
      sclk_prev_q <= sclk_s;
    end
  end

  assign hclk_tick = hclk_s && !hclk_prev_q;
  assign sclk_tick = sclk_s && !sclk_prev_q;

  // ****************************************************************************
  // Clock dividers
  // ****************************************************************************
  ptmr_prescale #(.DIV(`PTMR_DIV_SYS)) u_div_sys4 (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .in_tick(1'b1), .out_tick(sys4_tick));
  ptmr_prescale #(.DIV(`PTMR_DIV_H16)) u_div_h16 (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .in_tick(hclk_tick), .out_tick(h16_tick));
  ptmr_prescale #(.DIV(`PTMR_DIV_H64)) u_div_h64 (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .in_tick(hclk_tick), .out_tick(h64_tick));

  // ****************************************************************************
  // Pin routing and edge detection
  // ****************************************************************************
  always_comb begin
    ext_lvl = st_q.route[1] ? pb4_s : pa3_s; // [R2]
    cap_lvl = st_q.route[3] ? pb5_s : pa4_s; // [R1]
    ext_rise = ext_lvl && !st_q.ext_prev;
    ext_fall = !ext_lvl && st_q.ext_prev;
    cap_rise = cap_lvl && !st_q.cap_prev;
    cap_fall = !cap_lvl && st_q.cap_prev;
    src_rise = st_q.capsrc ? ext_rise : cap_rise; // [R9]
    src_fall = st_q.capsrc ? ext_fall : cap_fall; // [R9]
    unique case (st_q.cksel) // [R4]
      `PTMR_CK_SYS4: src_tick = sys4_tick;
      `PTMR_CK_SYS: src_tick = 1'b1;
      `PTMR_CK_H16: src_tick = h16_tick;
      `PTMR_CK_H64: src_tick = h64_tick;
      `PTMR_CK_SUB0: src_tick = sclk_tick;
      `PTMR_CK_SUB1: src_tick = sclk_tick;
      `PTMR_CK_EXTR: src_tick = ext_rise; // [R6]
      `PTMR_CK_EXTF: src_tick = ext_fall; // [R6]
    endcase
  end

  // ****************************************************************************
  // Counter, comparators, capture and output
  // ****************************************************************************
  always_comb begin
    st_d = st_q;
    st_d.irq_a = 1'b0;
    st_d.irq_p = 1'b0;
    st_d.ext_prev = ext_lvl;
    st_d.cap_prev = cap_lvl;
    st_d.on_prev = st_q.on;
    on_rise = st_q.on && !st_q.on_prev;
    // Single pulse mode holds the counter until its trigger arrives
    run = st_q.on && !st_q.pause && !(st_q.mode == `PTMR_MODE_PWM &&
      st_q.fn == `PTMR_FN_3 && !st_q.sp_run);
    cnt_tick = run && src_tick;
    match_a = cnt_tick && (st_q.cnt == st_q.cmp_a) && (st_q.mode != `PTMR_MODE_CAP); // [R19]
    match_p = cnt_tick && (st_q.cnt == st_q.per); // [R19]
    clear_hit = st_q.cclr ? match_a : match_p;
    cap_hit = 1'b0;
    if (st_q.mode == `PTMR_MODE_CAP && st_q.on) begin
      unique case (st_q.fn) // [R8]
        `PTMR_FN_0: cap_hit = src_rise;
        `PTMR_FN_1: cap_hit = src_fall;
        `PTMR_FN_2: cap_hit = src_rise || src_fall;
        `PTMR_FN_3: cap_hit = 1'b0;
      endcase
    end
    if (on_rise) begin
      st_d.cnt = `PTMR_RST_CNT;
      st_d.out = st_q.init;
      st_d.sp_run = 1'b0;
    end else if (cnt_tick) begin
      st_d.cnt = clear_hit ? `PTMR_RST_CNT : st_q.cnt + 10'h001; // [R3] [R19]
    end
    st_d.irq_a = match_a || cap_hit; // [R5]
    st_d.irq_p = match_p; // [R5]
    if (cap_hit) begin
      st_d.cmp_a = st_q.cnt; // [R21]
    end
    if (!on_rise && st_q.on) begin
      unique case (st_q.mode)
        `PTMR_MODE_CMP: begin
          if (match_a) begin
            unique case (st_q.fn) // [R10] [R3]
              `PTMR_FN_0: st_d.out = st_q.out;
              `PTMR_FN_1: st_d.out = 1'b0;
              `PTMR_FN_2: st_d.out = 1'b1;
              `PTMR_FN_3: st_d.out = !st_q.out;
            endcase
          end
        end
        `PTMR_MODE_PWM: begin
          unique case (st_q.fn)
            `PTMR_FN_0: st_d.out = 1'b0;
            `PTMR_FN_1: st_d.out = 1'b1;
            `PTMR_FN_2: st_d.out = (st_d.cnt < st_q.cmp_a); // [R10] [R11]
            `PTMR_FN_3: begin
              if (!st_q.sp_run && ext_rise) begin
                st_d.sp_run = 1'b1; // [R7]
                st_d.out = 1'b1;
                st_d.cnt = `PTMR_RST_CNT;
              end else if (st_q.sp_run && match_a) begin
                st_d.sp_run = 1'b0;
                st_d.out = 1'b0;
              end
            end
          endcase
        end
        `PTMR_MODE_CAP: st_d.out = st_q.out;
        `PTMR_MODE_TMR: st_d.out = st_q.out;
      endcase
    end

    // ****************************************************************************
    // Register access; bus writes win over a capture in the same cycle
    // ****************************************************************************
    if (reg_wr) begin
      unique case (reg_addr)
        `PTMR_ADDR_CTRL0: begin
          st_d.pause = reg_wdata[`PTMR_C0_PAUSE];
          st_d.cksel = reg_wdata[`PTMR_C0_CKSEL];
          st_d.on = reg_wdata[`PTMR_C0_ON];
        end
        `PTMR_ADDR_CTRL1: begin
          st_d.mode = reg_wdata[`PTMR_C1_MODE];
          st_d.fn = reg_wdata[`PTMR_C1_FN];
          st_d.init = reg_wdata[`PTMR_C1_INIT];
          st_d.pol = reg_wdata[`PTMR_C1_POL];
          st_d.capsrc = reg_wdata[`PTMR_C1_CAPSRC];
          st_d.cclr = reg_wdata[`PTMR_C1_CCLR];
        end
        `PTMR_ADDR_ROUTE: st_d.route = reg_wdata[3:0];
        `PTMR_ADDR_CMPA_LO: st_d.lo_buf = reg_wdata; // [R14]
        `PTMR_ADDR_PER_LO: st_d.lo_buf = reg_wdata; // [R14] [R11]
        `PTMR_ADDR_CMPA_HI: st_d.cmp_a = {reg_wdata[`PTMR_HI_BITS], st_q.lo_buf}; // [R15]
        `PTMR_ADDR_PER_HI: st_d.per = {reg_wdata[`PTMR_HI_BITS], st_q.lo_buf}; // [R15] [R11]
        default: st_d.lo_buf = st_q.lo_buf;
      endcase
    end
    st_d.rdata = `PTMR_RST_BYTE;
    if (reg_rd) begin
      unique case (reg_addr)
        `PTMR_ADDR_CTRL0: st_d.rdata = {st_q.pause, st_q.cksel, st_q.on, 3'h0};
        `PTMR_ADDR_CTRL1: st_d.rdata = {st_q.mode, st_q.fn, st_q.init, st_q.pol,
          st_q.capsrc, st_q.cclr};
        `PTMR_ADDR_ROUTE: st_d.rdata = {4'h0, st_q.route};
        `PTMR_ADDR_CNT_HI: begin
          st_d.rdata = {6'h00, st_q.cnt[9:8]}; // [R13] [R16]
          st_d.lo_buf = st_q.cnt[7:0];
        end
        `PTMR_ADDR_CMPA_HI: begin
          st_d.rdata = {6'h00, st_q.cmp_a[9:8]}; // [R16]
          st_d.lo_buf = st_q.cmp_a[7:0];
        end
        `PTMR_ADDR_PER_HI: begin
          st_d.rdata = {6'h00, st_q.per[9:8]}; // [R16]
          st_d.lo_buf = st_q.per[7:0];
        end
        `PTMR_ADDR_CNT_LO: st_d.rdata = st_q.lo_buf; // [R17]
        `PTMR_ADDR_CMPA_LO: st_d.rdata = st_q.lo_buf; // [R17]
        `PTMR_ADDR_PER_LO: st_d.rdata = st_q.lo_buf; // [R17]
        default: st_d.rdata = `PTMR_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************************
  // Outputs
  // ****************************************************************************
  assign reg_rdata = st_q.rdata;
  assign timer_output_pin = st_q.out ^ st_q.pol;
  assign timer_output_inverted_pin = !(st_q.out ^ st_q.pol); // [R20]
  assign irq_compare_a = st_q.irq_a;
  assign irq_period = st_q.irq_p;

  // ****************************************************************************
  // Assertions
  // ****************************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_cmpa_hi_read;
    reg_rd && reg_addr == `PTMR_ADDR_CMPA_HI;
  endsequence

  sequence s_lo_read;
    reg_rd && (reg_addr == `PTMR_ADDR_CNT_LO || reg_addr == `PTMR_ADDR_CMPA_LO ||
      reg_addr == `PTMR_ADDR_PER_LO);
  endsequence

  a_pins_inverse: assert property ( // [R20]
    timer_output_inverted_pin == !timer_output_pin)
    else $error("inverted output pin does not mirror primary pin");

  a_low_write_only: assert property ( // [R14]
    reg_wr && reg_addr == `PTMR_ADDR_PER_LO |=> st_q.per == $past(st_q.per) &&
    st_q.lo_buf == $past(reg_wdata))
    else $error("low byte write touched the period value");

  a_high_write_join: assert property ( // [R15]
    reg_wr && reg_addr == `PTMR_ADDR_CMPA_HI |=>
    st_q.cmp_a == {$past(reg_wdata[1:0]), $past(st_q.lo_buf)})
    else $error("comparator A high write did not join the buffer");

  a_high_read_buf: assert property ( // [R16]
    s_cmpa_hi_read |=> st_q.lo_buf == $past(st_q.cmp_a[7:0]) &&
    reg_rdata == {6'h00, $past(st_q.cmp_a[9:8])})
    else $error("high read did not load the low buffer");

  a_low_read_buf: assert property ( // [R17]
    s_lo_read |=> reg_rdata == $past(st_q.lo_buf))
    else $error("low read did not return the buffer");

  a_match_a_event: assert property ( // [R5]
    cnt_tick && st_q.cnt == st_q.cmp_a && st_q.mode != `PTMR_MODE_CAP |=> irq_compare_a)
    else $error("comparator A match raised no event");

  a_match_p_clear: assert property ( // [R3]
    cnt_tick && !on_rise && !st_q.cclr && st_q.cnt == st_q.per &&
    st_q.mode != `PTMR_MODE_PWM |=> irq_period && st_q.cnt == `PTMR_RST_CNT)
    else $error("period match did not clear the counter");

  a_sys_clock_step: assert property ( // [R4]
    run && !on_rise && st_q.cksel == `PTMR_CK_SYS && st_q.mode == `PTMR_MODE_TMR &&
    st_q.cnt != st_q.per && st_q.cnt != st_q.cmp_a |=> st_q.cnt == $past(st_q.cnt) + 10'h001)
    else $error("counter did not step on the system clock");

  a_capture_latch: assert property ( // [R21]
    cap_hit && !reg_wr |=> st_q.cmp_a == $past(st_q.cnt) && irq_compare_a)
    else $error("capture did not latch the counter");
endmodule

// file: verif/ptmr_pins_model.sv
// Model of the external pins that drive the timer's clock and capture inputs
module ptmr_pins_model (
  input wire logic ref_clk,
  output logic port_a_bit_three,
  output logic port_a_bit_four,
  output logic port_b_bit_four,
  output logic port_b_bit_five
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************************
  // Pin levels
  // ****************************************************************************
  // Index 0 a3, 1 a4, 2 b4, 3 b5; idle low between pulses
  logic [3:0] pins_q = 4'h0;
  // Pin-sharing is taken as already set up, so pins reach the timer
  assign port_a_bit_three = pins_q[0];
  assign port_a_bit_four = pins_q[1];
  assign port_b_bit_four = pins_q[2];
  assign port_b_bit_five = pins_q[3];

  // Slow pulses: the synchroniser needs several cycles per level
  task automatic pulse(input int pin, input int n);
    repeat (n) begin
      @(posedge ref_clk) pins_q[pin] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      pins_q[pin] <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
  endtask
endmodule

// file: verif/ptmr_core_tb.sv
// Self-checking testbench of the periodic timer core
`include "ptmr_regs.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
  $display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module ptmr_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************************
  // Signals
  // ****************************************************************************
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic high_clk = 1'b0;
  logic sub_clk = 1'b0;
  logic [7:0] reg_rdata;
  logic a3, a4, b4, b5, tout, tout_n, irq_a, irq_p;
  int n_fail = 0;
  int check_count = 0;
  int n_a = 0;
  int n_per = 0;
  int n_hi = 0;
  int cyc = 0;
  logic [9:0] v;
  logic o;

  initial forever #4 ref_clk = ~ref_clk;
  // Slow internal clocks, well below half the system rate
  initial forever #40 high_clk = ~high_clk;
  initial forever #200 sub_clk = ~sub_clk;

  ptmr_core u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .port_a_bit_three(a3), .port_a_bit_four(a4), .port_b_bit_four(b4),
    .port_b_bit_five(b5), .high_clk(high_clk), .sub_clk(sub_clk),
    .timer_output_pin(tout), .timer_output_inverted_pin(tout_n),
    .irq_compare_a(irq_a), .irq_period(irq_p));
  ptmr_pins_model u_pins (.ref_clk(ref_clk), .port_a_bit_three(a3),
    .port_a_bit_four(a4), .port_b_bit_four(b4), .port_b_bit_five(b5));

  // ****************************************************************************
  // Monitors
  // ****************************************************************************
  always @(posedge ref_clk) begin
    if (irq_a === 1'b1) n_a++;
    if (irq_p === 1'b1) n_per++;
    if (tout === 1'b1) n_hi++;
    cyc++;
    // Ceiling well above the few thousand cycles the tests need
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  always @(negedge ref_clk) if (!sys_rst) `CHK(tout_n, ~tout)

  // ****************************************************************************
  // Bus tasks
  // ****************************************************************************
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk) begin
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
    end
    @(posedge ref_clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk) begin
      reg_rd <= 1'b1;
      reg_addr <= a;
    end
    @(posedge ref_clk) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Low byte first on write, high byte first on read
  task automatic wr16(input logic [3:0] lo, input logic [9:0] val);
    wr(lo, val[7:0]);
    wr(lo + 4'h1, {6'h00, val[9:8]});
  endtask
  task automatic rd16(input logic [3:0] lo, output logic [9:0] val);
    logic [7:0] h, l;
    rd(lo + 4'h1, h);
    rd(lo, l);
    val = {h[1:0], l};
  endtask
  task automatic wait_clear(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
    n_a = 0;
    n_per = 0;
    n_hi = 0;
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************************************************
  // Tests
  // ****************************************************************************
  initial begin
    logic [7:0] d;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    `CHK(tout, 1'b0)
    // Reset values, unmapped address 9 included
    for (int i = 0; i < 10; i++) begin
      rd(i[3:0], d);
      `CHK(d, 8'h00)
    end
    // Buffered byte access
    wr16(`PTMR_ADDR_CMPA_LO, 10'h2a5);
    wr(`PTMR_ADDR_CMPA_LO, 8'h11);
    rd(`PTMR_ADDR_CMPA_LO, d);
    `CHK(d, 8'h11)
    rd16(`PTMR_ADDR_CMPA_LO, v);
    `CHK(v, 10'h2a5)
    wr16(`PTMR_ADDR_PER_LO, 10'h1c3);
    rd16(`PTMR_ADDR_PER_LO, v);
    `CHK(v, 10'h1c3)
    wr(`PTMR_ADDR_CNT_HI, 8'h03);
    rd(`PTMR_ADDR_CNT_HI, d);
    `CHK(d, 8'h00)
    // Timer mode on the system clock, period 2 gives 3-cycle repeats
    wr16(`PTMR_ADDR_PER_LO, 10'h002);
    wr(`PTMR_ADDR_CTRL1, 8'hc0);
    wr(`PTMR_ADDR_CTRL0, 8'h18);
    wait_clear(10);
    repeat (30) @(posedge ref_clk);
    #1 `CHK(n_per, 10)
    `CHK(n_a, 0)
    // Divided system clock: one tick per 4 cycles, so 12-cycle repeats
    wr(`PTMR_ADDR_CTRL0, 8'h08);
    wait_clear(10);
    repeat (36) @(posedge ref_clk);
    #1 `CHK(n_per, 3)
    // High clock over 16: one tick per 160 cycles, 480-cycle repeats
    wr(`PTMR_ADDR_CTRL0, 8'h28);
    wait_clear(500);
    repeat (960) @(posedge ref_clk);
    #1 `CHK(n_per, 2)
    // Sub clock: one tick per 50 cycles, 150-cycle repeats
    wr(`PTMR_ADDR_CTRL0, 8'h48);
    wait_clear(200);
    repeat (300) @(posedge ref_clk);
    #1 `CHK(n_per, 2)
    // Compare output mode, toggle on A match, period 4 cycles
    wr(`PTMR_ADDR_CTRL0, 8'h00);
    wr16(`PTMR_ADDR_CMPA_LO, 10'h001);
    wr16(`PTMR_ADDR_PER_LO, 10'h003);
    wr(`PTMR_ADDR_CTRL1, 8'h30);
    wr(`PTMR_ADDR_CTRL0, 8'h18);
    wait_clear(10);
    o = tout;
    repeat (40) @(posedge ref_clk);
    #1 `CHK(n_a, 10)
    `CHK(n_per, 10)
    `CHK(tout, o)
    repeat (4) @(posedge ref_clk);
    #1 `CHK(tout, ~o)
    // PWM: duty follows comparator A, period follows the period comparator
    wr(`PTMR_ADDR_CTRL0, 8'h00);
    wr(`PTMR_ADDR_CTRL1, 8'ha0);
    wr(`PTMR_ADDR_CTRL0, 8'h18);
    wait_clear(10);
    repeat (40) @(posedge ref_clk);
    #1 `CHK(n_hi, 10)
    wr16(`PTMR_ADDR_CMPA_LO, 10'h002);
    wait_clear(10);
    repeat (40) @(posedge ref_clk);
    #1 `CHK(n_hi, 20)
    // External clock pin, rising edge, routed from port B then port A
    wr(`PTMR_ADDR_CTRL0, 8'h00);
    wr16(`PTMR_ADDR_PER_LO, 10'h3ff);
    wr16(`PTMR_ADDR_CMPA_LO, 10'h300);
    wr(`PTMR_ADDR_CTRL1, 8'hc0);
    wr(`PTMR_ADDR_ROUTE, 8'h02);
    wr(`PTMR_ADDR_CTRL0, 8'h68);
    u_pins.pulse(0, 3);
    u_pins.pulse(2, 5);
    repeat (8) @(posedge ref_clk);
    rd16(`PTMR_ADDR_CNT_LO, v);
    `CHK(v, 10'h005)
    wr(`PTMR_ADDR_ROUTE, 8'h00);
    u_pins.pulse(2, 4);
    u_pins.pulse(0, 2);
    repeat (8) @(posedge ref_clk);
    rd16(`PTMR_ADDR_CNT_LO, v);
    `CHK(v, 10'h007)
    // Capture on rising edge from port B bit five into comparator A
    wr(`PTMR_ADDR_CTRL0, 8'h00);
    wr(`PTMR_ADDR_CTRL1, 8'h40);
    wr(`PTMR_ADDR_ROUTE, 8'h0a);
    wr(`PTMR_ADDR_CTRL0, 8'h68);
    u_pins.pulse(2, 6);
    wait_clear(8);
    u_pins.pulse(1, 1);
    u_pins.pulse(3, 1);
    repeat (8) @(posedge ref_clk);
    `CHK(n_a, 1)
    rd16(`PTMR_ADDR_CMPA_LO, v);
    `CHK(v, 10'h006)
    // Single pulse: port B bit four rise starts it, A match at 3 ends it
    wr(`PTMR_ADDR_CTRL0, 8'h00);
    wr16(`PTMR_ADDR_CMPA_LO, 10'h003);
    wr(`PTMR_ADDR_CTRL1, 8'hb0);
    wr(`PTMR_ADDR_CTRL0, 8'h18);
    wait_clear(4);
    u_pins.pulse(2, 1);
    repeat (8) @(posedge ref_clk);
    #1 `CHK(n_hi, 4)
    `CHK(n_a, 1)
    // Falling-edge capture from the clock pin, which also counts on falls
    wr(`PTMR_ADDR_CTRL0, 8'h00);
    wr(`PTMR_ADDR_CTRL1, 8'h52);
    wr(`PTMR_ADDR_CTRL0, 8'h78);
    wait_clear(4);
    u_pins.pulse(3, 1);
    u_pins.pulse(2, 2);
    repeat (8) @(posedge ref_clk);
    #1 `CHK(n_a, 2)
    rd16(`PTMR_ADDR_CMPA_LO, v);
    `CHK(v, 10'h001)
    end_of_test();
  end
endmodule
